// *** logic/exec_pkg.sv ***
// shared types and constants of the branch, skip, load and store executor
package exec_pkg;
    // status register bit positions
    localparam int C_BIT = 0;
    localparam int Z_BIT = 1;
    localparam int N_BIT = 2;
    localparam int V_BIT = 3;
    localparam int H_BIT = 5;
    localparam int T_BIT = 6;

    // pointer pair selection
    localparam logic [1:0] PTR_X = 2'h0;
    localparam logic [1:0] PTR_Y = 2'h1;
    localparam logic [1:0] PTR_Z = 2'h2;

    // program counter and pointer steps
    localparam logic [15:0] SKIP_ONE_WORD = 16'h0002;
    localparam logic [15:0] SKIP_TWO_WORD = 16'h0003;
    localparam logic [15:0] BRANCH_BIAS   = 16'h0001;
    localparam logic [15:0] PTR_STEP      = 16'h0001;

    // clocks spent beyond the first one
    localparam logic [1:0] EXTRA_STORE    = 2'h1;
    localparam logic [1:0] EXTRA_BRANCH   = 2'h1;
    localparam logic [1:0] EXTRA_SKIP_ONE = 2'h1;
    localparam logic [1:0] EXTRA_SKIP_TWO = 2'h2;
    localparam logic [1:0] STALL_LAST     = 2'h1;

    typedef enum logic [5:0] {
        nop_op, compare_reg_op, compare_with_carry_op, compare_immediate_op,
        skip_reg_bit_clear_op, skip_reg_bit_set_op,
        skip_port_bit_clear_op, skip_port_bit_set_op,
        branch_status_bit_set_op, branch_status_bit_clear_op,
        branch_equal_op, branch_not_equal_op,
        branch_carry_set_op, branch_carry_clear_op,
        branch_same_higher_op, branch_lower_op,
        branch_minus_op, branch_plus_op,
        branch_signed_ge_op, branch_signed_lt_op,
        branch_halfcarry_set_op, branch_halfcarry_clear_op,
        branch_transfer_set_op, branch_transfer_clear_op,
        branch_overflow_set_op, branch_overflow_clear_op,
        register_move_op, register_pair_copy_op, load_immediate_op,
        indirect_load_op, displacement_load_op, direct_load_op,
        indirect_store_op
    } exec_op_type;

    typedef enum logic [1:0] {
        PTR_PLAIN    = 2'h0,
        PTR_POST_INC = 2'h1,
        PTR_PRE_DEC  = 2'h2
    } ptr_mode_type;

    typedef struct packed {
        exec_op_type  op;
        logic [4:0]   dst;
        logic [7:0]   dstVal;
        logic [15:0]  srcVal;
        logic [7:0]   imm;
        logic [2:0]   bitSel;
        logic [6:0]   offset;
        logic [5:0]   disp;
        logic [1:0]   ptrSel;
        ptr_mode_type ptrMode;
        logic [15:0]  ptrVal;
        logic [15:0]  absAddr;
        logic [7:0]   ioVal;
        logic         nextTwoWord;
        logic [15:0]  pc;
    } exec_req_type;

    typedef struct packed {
        logic        we;
        logic        pair;
        logic [4:0]  idx;
        logic [15:0] data;
    } reg_wr_type;

    typedef struct packed {
        logic        we;
        logic [1:0]  sel;
        logic [15:0] value;
    } ptr_wr_type;

    typedef struct packed {
        logic       we;
        logic [7:0] value;
    } status_wr_type;

    typedef struct packed {
        logic        we;
        logic [15:0] value;
    } pc_wr_type;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mem_req_type;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_STALL = 3'b010,
        ST_MEM   = 3'b100
    } state_type;
endpackage

// *** logic/compare_flags.sv ***
// flag result of compare and compare-with-carry
`timescale 1ns/100ps
`default_nettype none
module compare_flags (
    // operands
    input  wire logic [7:0] lhs,
    input  wire logic [7:0] rhs,
    input  wire logic       withCarry,
    // status in and out
    input  wire logic [7:0] statusIn,
    output logic [7:0]      statusOut
);
    import exec_pkg::*;

    wire logic       borrowIn = withCarry & statusIn[C_BIT];
    wire logic [8:0] diff     = {1'b0, lhs} - {1'b0, rhs} - {8'h00, borrowIn};
    wire logic [4:0] lowDiff  = {1'b0, lhs[3:0]} - {1'b0, rhs[3:0]} - {4'h0, borrowIn};
    // carry variant keeps zero only while the whole chain is zero
    wire logic       isZero   = (diff[7:0] == 8'h00) & (~withCarry | statusIn[Z_BIT]);
    wire logic       ovf      = (lhs[7] & ~rhs[7] & ~diff[7]) | (~lhs[7] & rhs[7] & diff[7]);

    always_comb begin
        statusOut = statusIn;
        statusOut[C_BIT] = diff[8];
        statusOut[Z_BIT] = isZero;
        statusOut[N_BIT] = diff[7];
        statusOut[V_BIT] = ovf;
        statusOut[H_BIT] = lowDiff[4];
    end
endmodule
`default_nettype wire

// *** logic/branch_condition.sv ***
// taken decision for skips and conditional relative branches
`timescale 1ns/100ps
`default_nettype none
module branch_condition (
    // instruction and operands
    input  wire exec_pkg::exec_op_type op,
    input  wire logic [7:0]            status,
    input  wire logic [2:0]            bitSel,
    input  wire logic [7:0]            regVal,
    input  wire logic [7:0]            ioVal,
    // decision
    output logic                       isSkip,
    output logic                       isBranch,
    output logic                       taken
);
    import exec_pkg::*;

    assign isSkip = op inside {skip_reg_bit_clear_op, skip_reg_bit_set_op,
                               skip_port_bit_clear_op, skip_port_bit_set_op};
    assign isBranch = (op >= branch_status_bit_set_op) && (op <= branch_overflow_clear_op);

    always_comb begin
        case (op)
            skip_reg_bit_clear_op:      taken = ~regVal[bitSel];
            skip_reg_bit_set_op:        taken = regVal[bitSel];
            skip_port_bit_clear_op:     taken = ~ioVal[bitSel];
            skip_port_bit_set_op:       taken = ioVal[bitSel];
            branch_status_bit_set_op:   taken = status[bitSel];
            branch_status_bit_clear_op: taken = ~status[bitSel];
            branch_equal_op:            taken = status[Z_BIT];
            branch_not_equal_op:        taken = ~status[Z_BIT];
            branch_carry_set_op:        taken = status[C_BIT];
            branch_carry_clear_op:      taken = ~status[C_BIT];
            branch_lower_op:            taken = status[C_BIT];
            branch_same_higher_op:      taken = ~status[C_BIT];
            branch_minus_op:            taken = status[N_BIT];
            branch_plus_op:             taken = ~status[N_BIT];
            branch_signed_ge_op:        taken = ~(status[N_BIT] ^ status[V_BIT]);
            branch_signed_lt_op:        taken = status[N_BIT] ^ status[V_BIT];
            branch_halfcarry_set_op:    taken = status[H_BIT];
            branch_halfcarry_clear_op:  taken = ~status[H_BIT];
            branch_transfer_set_op:     taken = status[T_BIT];
            branch_transfer_clear_op:   taken = ~status[T_BIT];
            branch_overflow_set_op:     taken = status[V_BIT];
            branch_overflow_clear_op:   taken = ~status[V_BIT];
            default:                    taken = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// *** logic/branch_skip_load_store_exec.sv ***
// executor for compares, skips, conditional branches and data transfers
//
// Contract
// - compares subtract operand (and carry) from register, set five flags, one clock
// - register bit skip advances past next instruction on selected bit test
// - port bit skip tests an I/O bit, flags untouched, one to three clocks
// - generic status branch jumps to pc plus offset plus one when bit matches
// - carry branches follow carry set or clear, flags untouched
// - same-or-higher uses carry clear, lower uses carry set
// - signed greater-or-equal is taken when negative xor overflow is zero
// - signed less-than is taken when negative xor overflow is one
// - half-carry branches take one clock untaken, two when taken
// - transfer-bit branches follow the transfer flag, no flag changes
// - overflow branches target pc plus offset plus one
// - post-increment load reads at pointer then bumps pointer, two clocks
// - pre-decrement load lowers pointer first then reads there, two clocks
// - displacement load reads pointer plus offset, second and third pairs only
// - direct load reads absolute address into register, two clocks
// - indirect store writes register at pointer, optional post-increment or pre-decrement, two clocks
`timescale 1ns/100ps
`default_nettype none
module branch_skip_load_store_exec (
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    input  wire logic                   ce,
    // decoded instruction
    input  wire logic                   reqValid,
    input  wire exec_pkg::exec_req_type req,
    input  wire logic [7:0]             status,
    output logic                        reqReady,
    // data memory bus
    output var exec_pkg::mem_req_type   memReq,
    input  wire logic [7:0]             memRdata,
    // write-back
    output var exec_pkg::reg_wr_type    regWr,
    output var exec_pkg::ptr_wr_type    ptrWr,
    output var exec_pkg::status_wr_type statusWr,
    output var exec_pkg::pc_wr_type     pcWr,
    output logic                        done,
    output logic                        illegalOp
);
    import exec_pkg::*;

    state_type     state_r,    state_nxt;
    logic [1:0]    stall_r,    stall_nxt;
    logic          ready_r,    ready_nxt;
    logic [4:0]    loadDst_r,  loadDst_nxt;
    reg_wr_type    regWr_r,    regWr_nxt;
    ptr_wr_type    ptrWr_r,    ptrWr_nxt;
    status_wr_type statusWr_r, statusWr_nxt;
    pc_wr_type     pcWr_r,     pcWr_nxt;
    mem_req_type   memReq_r,   memReq_nxt;
    logic          done_r,     done_nxt;
    logic          illegal_r,  illegal_nxt;

    // request decode
    wire exec_op_type  op       = req.op;
    wire logic [15:0]  reqPc    = req.pc;
    wire logic [15:0]  reqPtr   = req.ptrVal;
    wire logic         accept   = ce & reqValid & ready_r;
    wire logic         isCmp    = op inside {compare_reg_op, compare_with_carry_op,
                                             compare_immediate_op};
    wire logic         isMove   = op inside {register_move_op, register_pair_copy_op,
                                             load_immediate_op};
    wire logic         isLoad   = op inside {indirect_load_op, displacement_load_op,
                                             direct_load_op};
    wire logic         isStore  = (op == indirect_store_op);
    wire logic         isDisp   = (op == displacement_load_op);
    wire logic         dispBad  = isDisp & (req.ptrSel == PTR_X);
    wire logic         ptrStep  = ((op == indirect_load_op) | isStore)
                                  & (req.ptrMode != PTR_PLAIN);
    wire logic         preDec   = ptrStep & (req.ptrMode == PTR_PRE_DEC);
    wire logic [15:0]  ptrDec   = reqPtr - PTR_STEP;
    wire logic [15:0]  ptrInc   = reqPtr + PTR_STEP;
    wire logic [15:0]  dispExt  = {10'h000, req.disp};
    wire logic [15:0]  offsetExt = {{9{req.offset[6]}}, req.offset};

    // effective data address and pointer write-back value
    wire logic [15:0]  memAddr  = (op == direct_load_op) ? req.absAddr :
                                  isDisp ? reqPtr + dispExt :
                                  preDec ? ptrDec : reqPtr;
    wire logic [15:0]  ptrNew   = preDec ? ptrDec : ptrInc;

    // move sources
    wire logic [15:0]  moveData = (op == register_pair_copy_op) ? req.srcVal :
                                  (op == load_immediate_op) ? {8'h00, req.imm} :
                                  {8'h00, req.srcVal[7:0]};
    wire logic [7:0]   cmpRhs   = (op == compare_immediate_op) ? req.imm : req.srcVal[7:0];

    // program counter targets and extra clocks
    wire logic [15:0]  branchTarget = reqPc + offsetExt + BRANCH_BIAS;
    wire logic [15:0]  skipTarget   = reqPc + (req.nextTwoWord ? SKIP_TWO_WORD : SKIP_ONE_WORD);

    logic [7:0] cmpStatus;
    logic       isSkip;
    logic       isBranch;
    logic       taken;

    wire logic [15:0]  ctrlTarget = isSkip ? skipTarget : branchTarget;
    wire logic [1:0]   ctrlExtra  = !isSkip ? EXTRA_BRANCH :
                                    req.nextTwoWord ? EXTRA_SKIP_TWO : EXTRA_SKIP_ONE;

    compare_flags cmpUnit (
        .lhs       (req.dstVal),
        .rhs       (cmpRhs),
        .withCarry (op == compare_with_carry_op),
        .statusIn  (status),
        .statusOut (cmpStatus)
    );

    branch_condition condUnit (
        .op       (op),
        .status   (status),
        .bitSel   (req.bitSel),
        .regVal   (req.srcVal[7:0]),
        .ioVal    (req.ioVal),
        .isSkip   (isSkip),
        .isBranch (isBranch),
        .taken    (taken)
    );

    // next state and one-cycle write-back strobes
    always_comb begin
        state_nxt    = state_r;
        stall_nxt    = stall_r;
        ready_nxt    = ready_r;
        loadDst_nxt  = loadDst_r;
        regWr_nxt    = '0;
        ptrWr_nxt    = '0;
        statusWr_nxt = '0;
        pcWr_nxt     = '0;
        memReq_nxt   = '0;
        done_nxt     = 1'b0;
        illegal_nxt  = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (accept) begin
                    if (isCmp) begin
                        statusWr_nxt = {1'b1, cmpStatus};
                        done_nxt = 1'b1;
                    end else if (isMove) begin
                        regWr_nxt = {1'b1, op == register_pair_copy_op, req.dst, moveData};
                        done_nxt = 1'b1;
                    end else if (dispBad) begin
                        illegal_nxt = 1'b1;
                        done_nxt = 1'b1;
                    end else if (isLoad) begin
                        memReq_nxt = {1'b1, 1'b0, memAddr, 8'h00};
                        ptrWr_nxt = {ptrStep, req.ptrSel, ptrNew};
                        loadDst_nxt = req.dst;
                        ready_nxt = 1'b0;
                        state_nxt = ST_MEM;
                    end else if (isStore) begin
                        memReq_nxt = {1'b0, 1'b1, memAddr, req.srcVal[7:0]};
                        ptrWr_nxt = {ptrStep, req.ptrSel, ptrNew};
                        stall_nxt = EXTRA_STORE;
                        ready_nxt = 1'b0;
                        state_nxt = ST_STALL;
                    end else if ((isSkip | isBranch) & taken) begin
                        pcWr_nxt = {1'b1, ctrlTarget};
                        stall_nxt = ctrlExtra;
                        ready_nxt = 1'b0;
                        state_nxt = ST_STALL;
                    end else begin
                        done_nxt = 1'b1;
                    end
                end
            end
            ST_MEM: begin
                regWr_nxt = {1'b1, 1'b0, loadDst_r, 8'h00, memRdata};
                done_nxt = 1'b1;
                ready_nxt = 1'b1;
                state_nxt = ST_IDLE;
            end
            ST_STALL: begin
                if (stall_r == STALL_LAST) begin
                    done_nxt = 1'b1;
                    ready_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end else begin
                    stall_nxt = stall_r - STALL_LAST;
                end
            end
            default: begin
                ready_nxt = 1'b1;
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_r    <= ST_IDLE;
            stall_r    <= 2'h0;
            ready_r    <= 1'b1;
            loadDst_r  <= 5'h00;
            regWr_r    <= '0;
            ptrWr_r    <= '0;
            statusWr_r <= '0;
            pcWr_r     <= '0;
            memReq_r   <= '0;
            done_r     <= 1'b0;
            illegal_r  <= 1'b0;
        end else if (ce) begin
            state_r    <= state_nxt;
            stall_r    <= stall_nxt;
            ready_r    <= ready_nxt;
            loadDst_r  <= loadDst_nxt;
            regWr_r    <= regWr_nxt;
            ptrWr_r    <= ptrWr_nxt;
            statusWr_r <= statusWr_nxt;
            pcWr_r     <= pcWr_nxt;
            memReq_r   <= memReq_nxt;
            done_r     <= done_nxt;
            illegal_r  <= illegal_nxt;
        end
    end

    assign reqReady  = ready_r;
    assign memReq    = memReq_r;
    assign regWr     = regWr_r;
    assign ptrWr     = ptrWr_r;
    assign statusWr  = statusWr_r;
    assign pcWr      = pcWr_r;
    assign done      = done_r;
    assign illegalOp = illegal_r;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n || !ce);

    wire logic finishNext = done_r && ready_r;
    sequence loadCycle;
        memReq_r.rd && !ready_r ##1 regWr_r.we && regWr_r.data[7:0] == $past(memRdata)
            && finishNext;
    endsequence

    cmp_flags_a: assert property (
        accept && isCmp |=> statusWr_r.we && !regWr_r.we && finishNext
            && statusWr_r.value[T_BIT] == $past(status[T_BIT]))
        else $error("compare did not update flags in one clock");
    skip_reg_a: assert property (
        accept && op == skip_reg_bit_clear_op |=> pcWr_r.we == !$past(req.srcVal[req.bitSel]))
        else $error("register bit skip took wrong decision");
    skip_port_a: assert property (
        accept && op == skip_port_bit_set_op |=> pcWr_r.we == $past(req.ioVal[req.bitSel])
            && !statusWr_r.we)
        else $error("port bit skip took wrong decision");
    branch_generic_a: assert property (
        accept && op == branch_status_bit_clear_op |=> pcWr_r.we == !$past(status[req.bitSel]))
        else $error("status bit branch took wrong decision");
    branch_carry_a: assert property (
        accept && op == branch_carry_set_op |=> pcWr_r.we == $past(status[C_BIT])
            && !statusWr_r.we)
        else $error("carry branch took wrong decision");
    branch_unsigned_a: assert property (
        accept && op == branch_same_higher_op |=> pcWr_r.we == !$past(status[C_BIT]))
        else $error("same-or-higher branch took wrong decision");
    branch_ge_a: assert property (
        accept && op == branch_signed_ge_op
            |=> pcWr_r.we == ($past(status[N_BIT]) ~^ $past(status[V_BIT])))
        else $error("signed ge branch took wrong decision");
    branch_lt_a: assert property (
        accept && op == branch_signed_lt_op
            |=> pcWr_r.we == ($past(status[N_BIT]) ^ $past(status[V_BIT])))
        else $error("signed lt branch took wrong decision");
    half_timing_a: assert property (
        accept && op == branch_halfcarry_set_op && status[H_BIT]
            |=> pcWr_r.we && !ready_r ##1 finishNext)
        else $error("taken half-carry branch not two clocks");
    half_untaken_a: assert property (
        accept && op == branch_halfcarry_clear_op && status[H_BIT]
            |=> !pcWr_r.we && finishNext)
        else $error("untaken half-carry branch not one clock");
    branch_transfer_a: assert property (
        accept && op == branch_transfer_set_op |=> pcWr_r.we == $past(status[T_BIT])
            && !statusWr_r.we)
        else $error("transfer branch took wrong decision");
    branch_target_a: assert property (
        accept && isBranch && taken
            |=> pcWr_r.value == $past(reqPc) + $past(offsetExt) + BRANCH_BIAS)
        else $error("branch target wrong");
    load_post_a: assert property (
        accept && op == indirect_load_op && req.ptrMode == PTR_POST_INC |=> loadCycle
            and (memReq_r.addr == $past(reqPtr) && ptrWr_r.value == $past(reqPtr) + PTR_STEP))
        else $error("post-increment load wrong");
    load_pre_a: assert property (
        accept && op == indirect_load_op && req.ptrMode == PTR_PRE_DEC |=> loadCycle
            and (memReq_r.addr == $past(reqPtr) - PTR_STEP && ptrWr_r.value == memReq_r.addr))
        else $error("pre-decrement load wrong");
    load_disp_a: assert property (
        accept && isDisp && !dispBad |=> loadCycle
            and (memReq_r.addr == $past(reqPtr) + $past(dispExt) && !ptrWr_r.we))
        else $error("displacement load wrong");
    disp_refuse_a: assert property (
        accept && dispBad |=> illegal_r && !memReq_r.rd && finishNext)
        else $error("displacement load on first pair not refused");
    load_direct_a: assert property (
        accept && op == direct_load_op |=> loadCycle and memReq_r.addr == $past(req.absAddr))
        else $error("direct load wrong");
    store_a: assert property (
        accept && isStore |=> memReq_r.wr && memReq_r.wdata == $past(req.srcVal[7:0])
            && !ready_r ##1 finishNext)
        else $error("store wrong");
    move_a: assert property (
        accept && isMove |=> regWr_r.we && !statusWr_r.we && finishNext)
        else $error("move not one clock");
    skip_two_a: assert property (
        accept && isSkip && taken && req.nextTwoWord
            |=> pcWr_r.value == $past(reqPc) + SKIP_TWO_WORD ##1 !ready_r ##1 finishNext)
        else $error("skip over two words wrong");
endmodule
`default_nettype wire

// *** dv/mem_model.sv ***
// data memory model answering reads in the same cycle
`timescale 1ns/100ps
`default_nettype none
module mem_model (
    // clock
    input  wire logic                 mclk,
    // bus
    input  wire exec_pkg::mem_req_type memReq,
    output logic [7:0]                memRdata
);
    import exec_pkg::*;
    logic [7:0] lastV_r = 8'h00;
    // released bus shows the inverse of the last value
    assign memRdata = memReq.rd ? (memReq.addr[7:0] ^ 8'h3c) : ~lastV_r;
    always_ff @(posedge mclk) begin
        if (memReq.rd) lastV_r <= memRdata;
    end
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench of the executor
`timescale 1ns/100ps
`default_nettype none
module tb;
    import exec_pkg::*;
    logic          mclk, reset_n, ce, reqValid, reqReady, done, ill, illegalOp, rdy;
    logic [7:0]    status, memRdata;
    exec_req_type  req, r;
    mem_req_type   memReq;
    reg_wr_type    regWr;
    ptr_wr_type    ptrWr;
    status_wr_type statusWr;
    pc_wr_type     pcWr;
    logic [15:0]   pcV, regV, ptrV, stV, rdA, wdV;
    int            error_cnt = 0, cmp_count = 0, cyc = 0, n;
    branch_skip_load_store_exec dut_u (.mclk(mclk), .reset_n(reset_n), .ce(ce),
        .reqValid(reqValid), .req(req), .status(status), .reqReady(reqReady),
        .memReq(memReq), .memRdata(memRdata), .regWr(regWr), .ptrWr(ptrWr),
        .statusWr(statusWr), .pcWr(pcWr), .done(done), .illegalOp(illegalOp));
    mem_model mem_u (.mclk(mclk), .memReq(memReq), .memRdata(memRdata));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            results();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // issue one request and collect every strobe until done
    task automatic run(input logic [7:0] s);
        req = r; status = s; reqValid = 1'b1; ill = 1'b0;
        {pcV, regV, ptrV, stV, rdA, wdV} = '1;
        rdy = 1'b1;
        @(posedge mclk);
        @(negedge mclk);
        reqValid = 1'b0; n = 1;
        forever begin
            if (pcWr.we) pcV = pcWr.value;
            if (regWr.we) regV = regWr.data;
            if (ptrWr.we) ptrV = ptrWr.value;
            if (statusWr.we) stV = {8'h00, statusWr.value};
            if (memReq.rd | memReq.wr) rdA = memReq.addr;
            if (memReq.wr) wdV = {8'h00, memReq.wdata};
            if (n == 1) rdy = reqReady;
            if (illegalOp) ill = 1'b1;
            if (done === 1'b1 || n == 8) break;
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
    endtask
    task automatic t_cmp;
        r = '0; r.op = compare_immediate_op; r.dstVal = 8'h10; r.imm = 8'h20;
        run(8'h00);
        chk(stV, 16'h0005);
        chk(16'(n), 16'h0001);
        r.op = compare_with_carry_op; r.dstVal = 8'h20; r.srcVal = 16'h001f;
        run(8'h03);
        chk(stV, 16'h0022);
        $display("compare test over");
    endtask
    task automatic t_br;
        r = '0; r.op = branch_signed_lt_op; r.pc = 16'h0100; r.offset = 7'h7e;
        run(8'h04);
        chk(pcV, 16'h00ff);
        chk(16'(n), 16'h0002);
        r.op = branch_signed_ge_op;
        run(8'h04);
        chk(pcV, 16'hffff);
        r.op = branch_halfcarry_clear_op;
        run(8'h20);
        chk(16'(n), 16'h0001);
        $display("branch test over");
    endtask
    task automatic t_skip;
        r = '0; r.op = skip_reg_bit_set_op; r.bitSel = 3'h3; r.srcVal = 16'h0008;
        r.nextTwoWord = 1'b1; r.pc = 16'h0040;
        run(8'h00);
        chk(pcV, 16'h0043);
        chk(16'(n), 16'h0003);
        $display("skip test over");
    endtask
    task automatic t_load;
        r = '0; r.op = indirect_load_op; r.ptrSel = PTR_Y; r.ptrVal = 16'h0200;
        r.ptrMode = PTR_POST_INC;
        run(8'h00);
        chk(rdA, 16'h0200);
        chk(regV, 16'h003c);
        chk(ptrV, 16'h0201);
        r.ptrMode = PTR_PRE_DEC;
        run(8'h00);
        chk(rdA, 16'h01ff);
        chk(regV, 16'h00c3);
        chk(16'(n), 16'h0002);
        r.op = displacement_load_op; r.ptrSel = PTR_X;
        run(8'h00);
        chk({15'h0, ill}, 16'h0001);
        chk(rdA, 16'hffff);
        $display("load test over");
    endtask
    task automatic t_misc;
        r = '0; r.op = indirect_store_op; r.ptrSel = PTR_Z; r.ptrVal = 16'h0300;
        r.ptrMode = PTR_POST_INC; r.srcVal = 16'h005a;
        run(8'h00);
        chk(wdV, 16'h005a);
        chk(rdA, 16'h0300);
        chk(ptrV, 16'h0301);
        chk({15'h0, rdy}, 16'h0000);
        chk(16'(n), 16'h0002);
        r = '0; r.op = register_pair_copy_op; r.dst = 5'h04; r.srcVal = 16'hbeef;
        run(8'h00);
        chk(regV, 16'hbeef);
        chk({15'h0, rdy}, 16'h0001);
        r.op = direct_load_op; r.absAddr = 16'h0455;
        run(8'h00);
        chk(rdA, 16'h0455);
        chk(regV, 16'h0069);
        r = '0; r.op = displacement_load_op; r.ptrSel = PTR_Z; r.ptrVal = 16'h0100;
        r.disp = 6'h3f;
        run(8'h00);
        chk(rdA, 16'h013f);
        chk(ptrV, 16'hffff);
        r = '0; r.op = skip_port_bit_clear_op; r.bitSel = 3'h1; r.ioVal = 8'hfd;
        r.pc = 16'h0010;
        run(8'h00);
        chk(pcV, 16'h0012);
        chk(stV, 16'hffff);
        chk(16'(n), 16'h0002);
        r.op = branch_carry_clear_op; r.offset = 7'h05;
        run(8'h01);
        chk(pcV, 16'hffff);
        r.op = branch_same_higher_op;
        run(8'h00);
        chk(pcV, 16'h0016);
        r.op = branch_transfer_set_op;
        run(8'h40);
        chk(pcV, 16'h0016);
        r.op = branch_overflow_set_op;
        run(8'h08);
        chk(pcV, 16'h0016);
        r.op = branch_halfcarry_set_op;
        run(8'h20);
        chk(16'(n), 16'h0002);
        r.op = branch_status_bit_clear_op; r.bitSel = 3'h7;
        run(8'h00);
        chk(pcV, 16'h0016);
        $display("misc test over");
    endtask
    task automatic results;
        $display("checks=%0d errors=%0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        ce = 1'b1; reqValid = 1'b0; req = '0; r = '0; status = 8'h00; reset_n = 1'b0;
        repeat (8) @(negedge mclk);
        reset_n = 1'b1;
        t_cmp;
        t_br;
        t_skip;
        t_load;
        t_misc;
        results();
    end
endmodule
`default_nettype wire
